/* File: src/dtc_pkg.sv */
// constants and helpers shared by the paired timer/counter block
// assumes a single system clock; all pins are synchronised in the top module
package dtc_pkg;

    // widths
    localparam int PRE_W  = 12;                  // prescaler chain, divides up to 4096
    localparam int BYTE_W = 8;
    localparam int WIDE_W = 16;
    localparam int PWM_W  = 10;
    localparam int HI_W   = 4;

    // lower clock select codes
    localparam logic [2:0] LSEL_DIV2    = 3'h0;
    localparam logic [2:0] LSEL_DIV4    = 3'h1;
    localparam logic [2:0] LSEL_DIV16   = 3'h2;
    localparam logic [2:0] LSEL_DIV64   = 3'h3;
    localparam logic [2:0] LSEL_DIV256  = 3'h4;
    localparam logic [2:0] LSEL_DIV1024 = 3'h5;
    localparam logic [2:0] LSEL_DIV4096 = 3'h6;
    localparam logic [2:0] LSEL_EXT     = 3'h7;

    // upper clock select codes
    localparam logic [1:0] USEL_DIV1  = 2'h0;
    localparam logic [1:0] USEL_DIV2  = 2'h1;
    localparam logic [1:0] USEL_DIV16 = 2'h2;
    localparam logic [1:0] USEL_CHAIN = 2'h3;

    // divide ratios as powers of two
    localparam int SH_DIV1    = 0;
    localparam int SH_DIV2    = 1;
    localparam int SH_DIV4    = 2;
    localparam int SH_DIV16   = 4;
    localparam int SH_DIV64   = 6;
    localparam int SH_DIV256  = 8;
    localparam int SH_DIV1024 = 10;
    localparam int SH_DIV4096 = 12;

    // field positions in the pwm high-bits register
    localparam int HI_PER_MSB  = 3;
    localparam int HI_PER_LSB  = 2;
    localparam int HI_DUTY_MSB = 1;
    localparam int HI_DUTY_LSB = 0;

    // reset values
    localparam logic [7:0] CMP_RESET  = 8'hff;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET  = 8'h00;
    localparam logic [7:0] CAP_RESET  = 8'h00;
    localparam logic [3:0] HI_RESET   = 4'h0;
    localparam logic [9:0] PWM_ZERO   = 10'h000;
    localparam logic [9:0] PWM_ONE    = 10'h001;

    // prescaler tap: true once every 2**shift system clocks
    function automatic logic pre_tap(input logic [PRE_W-1:0] cnt, input int shift);
        logic [PRE_W-1:0] mask;
        mask = PRE_W'((1 << shift) - 1);
        pre_tap = ((cnt & mask) == mask);
    endfunction : pre_tap

endpackage : dtc_pkg

/* File: src/dtc_prescaler.sv */
// free-running prescaler with the lower and upper divide taps
// assumes mclk is the main system clock; taps are one-cycle pulses
`timescale 1ns/100ps
module dtc_prescaler
    import dtc_pkg::*;
(
    input  wire logic       mclk,        // system clock
    input  wire logic       rst_n,       // sync reset, low
    input  wire logic [2:0] lower_sel,   // lower clock select
    input  wire logic [1:0] upper_sel,   // upper clock select
    output logic            lower_tap,   // lower divided tick
    output logic            upper_tap    // upper divided tick
);

    logic [PRE_W-1:0] pre_q;

    // one shared chain keeps all taps phase aligned
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    // lower tap; external code yields none here, the top takes the pin edge
    always_comb begin
        unique case (lower_sel)
            LSEL_DIV2:    lower_tap = pre_tap(pre_q, SH_DIV2);
            LSEL_DIV4:    lower_tap = pre_tap(pre_q, SH_DIV4);
            LSEL_DIV16:   lower_tap = pre_tap(pre_q, SH_DIV16);
            LSEL_DIV64:   lower_tap = pre_tap(pre_q, SH_DIV64);
            LSEL_DIV256:  lower_tap = pre_tap(pre_q, SH_DIV256);
            LSEL_DIV1024: lower_tap = pre_tap(pre_q, SH_DIV1024);
            LSEL_DIV4096: lower_tap = pre_tap(pre_q, SH_DIV4096);
            LSEL_EXT:     lower_tap = 1'b0;
        endcase
    end

    // upper tap; chain code is resolved in the top
    always_comb begin
        unique case (upper_sel)
            USEL_DIV1:  upper_tap = pre_tap(pre_q, SH_DIV1);
            USEL_DIV2:  upper_tap = pre_tap(pre_q, SH_DIV2);
            USEL_DIV16: upper_tap = pre_tap(pre_q, SH_DIV16);
            USEL_CHAIN: upper_tap = 1'b0;
        endcase
    end

    a_div16_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
        (upper_sel == USEL_DIV16 && upper_tap) |=> (upper_sel != USEL_DIV16 || !upper_tap) [*8])
        else $error("div16 tap repeated too early");

endmodule : dtc_prescaler

/* File: src/dtc_pwm.sv */
// 10-bit pwm generator for the upper counter
// assumes advance is a one-cycle source clock tick; level is registered
`timescale 1ns/100ps
module dtc_pwm
    import dtc_pkg::*;
(
    input  wire logic             mclk,      // system clock
    input  wire logic             rst_n,     // sync reset, low
    input  wire logic             enable,    // pwm enable bit
    input  wire logic             advance,   // source clock tick
    input  wire logic             polarity,  // duty level select
    input  wire logic [PWM_W-1:0] period,    // 10-bit period
    input  wire logic [PWM_W-1:0] duty,      // 10-bit duty
    output logic                  level      // waveform level
);

    logic [PWM_W-1:0] cnt_q;

    // period counter runs 0 .. period-1; a zero period holds it
    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin
            cnt_q <= PWM_ZERO;
        end else if (advance) begin
            if (cnt_q + PWM_ONE >= period) begin
                cnt_q <= PWM_ZERO;
            end else begin
                cnt_q <= cnt_q + PWM_ONE;
            end
        end
    end

    // output level; full and empty duty pinned to steady levels
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (duty == PWM_ZERO) begin
            level <= !polarity;
        end else if (duty >= period) begin
            level <= polarity;
        end else begin
            level <= (cnt_q < duty) ? polarity : !polarity;
        end
    end

    a_pwm_zero_duty: assert property (@(posedge mclk) disable iff (!rst_n)
        (duty == PWM_ZERO) ##1 (duty == PWM_ZERO) |-> level == !$past(polarity))
        else $error("zero duty level wrong");

    a_pwm_full_duty: assert property (@(posedge mclk) disable iff (!rst_n)
        (duty != PWM_ZERO && duty == period) |=> level == $past(polarity))
        else $error("full duty level wrong");

    a_pwm_cnt_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        (enable && period != PWM_ZERO && $stable(period)) |-> ##1 cnt_q < period)
        else $error("pwm counter passed period");

endmodule : dtc_pwm

/* File: src/dtc_timer_top.sv */
// paired 8-bit timer/event counters, joinable into one 16-bit counter
// assumes pins are asynchronous to mclk; control bits come from a register file
// outside, with write strobes for the compare and pwm bytes
`timescale 1ns/100ps
// Operation
// - two independent 8-bit counters, or one joined 16-bit counter.
// - lower clock: main clock over 2..4096, or external count input.
// - upper clock: main clock over 1, 2, 16, or lower overflow.
// - external source counts on each rising edge of the pin.
// - external source selected forces count pin to input direction.
// - in 8-bit mode each counter flags interrupt on compare match, the upper one only outside pwm mode.
// - 16-bit mode wraps at joint compare; only lower interrupt raised.
// - lower byte is least significant, upper byte most significant.
// - capture trigger copies the count into the capture register.
// - capture mode keeps match interrupt; capture clears and restarts count.
// - in capture mode the shared read returns capture, not counter.
// - 16-bit capture captures the full 16-bit count.
// - upper pin carries 10-bit pwm only when upper output enabled.
// - period and duty are high bits above the period and duty bytes.
// - nonzero duty equal to period holds output at the polarity level.
// - zero duty holds output at the opposite of polarity.
// - compare-output mode toggles the pin on each count match.
// - lower counter drives its compare result onto its own pin.
// - lower compare is write-only, resets to all ones.
module dtc_timer_top
    import dtc_pkg::*;
(
    input  wire logic       mclk,                   // system clock, 25 MHz
    input  wire logic       rst_n,                  // sync reset, low
    input  wire logic       lower_enable,           // lower counter runs
    input  wire logic       lower_output_enable,    // lower pin drive enable
    input  wire logic       lower_capture_select,   // lower capture mode
    input  wire logic [2:0] lower_clock_select,     // lower clock source
    input  wire logic       upper_enable,           // upper counter runs
    input  wire logic       duty_level_select,      // pwm polarity
    input  wire logic       wide_mode_select,       // join into 16 bits
    input  wire logic       pwm_enable_bit,         // upper in pwm mode
    input  wire logic       upper_capture_select,   // upper capture mode
    input  wire logic [1:0] upper_clock_select,     // upper clock source
    input  wire logic       lower_cmp_wr,           // write lower compare
    input  wire logic       upper_cmp_wr,           // write upper compare / period
    input  wire logic       pwm_duty_wr,            // write duty byte
    input  wire logic       pwm_high_wr,            // write high-bits register
    input  wire logic [7:0] wr_data,                // write data byte
    input  wire logic       external_count_input,   // count pin
    input  wire logic       lower_capture_trigger,  // lower capture pin
    input  wire logic       upper_capture_trigger,  // upper capture pin
    output logic      [7:0] lower_read_value,       // counter or capture
    output logic      [7:0] upper_read_value,       // counter or capture
    output logic      [7:0] pwm_duty_read,          // duty byte readback
    output logic            lower_irq,              // lower match pulse
    output logic            upper_irq,              // upper match pulse
    output logic            lower_wave_pin,         // lower compare pin
    output logic            upper_wave_pin,         // upper compare/pwm pin
    output logic            ext_pin_input_mode      // count pin forced input
);

    // synchronisers: s1 -> s2 -> s3 edge stage
    logic [2:0] ext_s_q;
    logic [2:0] ltrg_s_q;
    logic [2:0] utrg_s_q;
    logic       ext_rise;
    logic       ltrg_rise;
    logic       utrg_rise;

    // software-written values
    logic [7:0] lower_compare_value_q;
    logic [7:0] upper_compare_value_q;    // doubles as pwm period byte
    logic [7:0] pwm_duty_byte_q;
    logic [3:0] pwm_high_q;
    logic       upper_output_enable_q;

    // counters and captures
    logic [7:0] lower_counter_q;
    logic [7:0] upper_counter_q;
    logic [7:0] lower_capture_value_q;
    logic [7:0] upper_capture_value_q;
    logic       lower_tog_q;
    logic       upper_tog_q;

    logic       lower_tap;
    logic       upper_tap;
    logic       lower_tick;
    logic       upper_tick;
    logic       lower_match;
    logic       upper_match;
    logic       wide_match;
    logic       lower_wrap;
    logic       upper_wrap;
    logic       lower_cap_evt;
    logic       upper_cap_evt;
    logic       pwm_level;
    logic [WIDE_W-1:0] wide_count;
    logic [WIDE_W-1:0] wide_cmp;

    // the first stage is read only by the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_s_q  <= 3'h0;
            ltrg_s_q <= 3'h0;
            utrg_s_q <= 3'h0;
        end else begin
            ext_s_q  <= {ext_s_q[1:0], external_count_input};
            ltrg_s_q <= {ltrg_s_q[1:0], lower_capture_trigger};
            utrg_s_q <= {utrg_s_q[1:0], upper_capture_trigger};
        end
    end

    // rising edges seen from the settled stages
    assign ext_rise  = ext_s_q[1] && !ext_s_q[2];
    assign ltrg_rise = ltrg_s_q[1] && !ltrg_s_q[2];
    assign utrg_rise = utrg_s_q[1] && !utrg_s_q[2];

    dtc_prescaler u_pre (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .lower_sel (lower_clock_select),
        .upper_sel (upper_clock_select),
        .lower_tap (lower_tap),
        .upper_tap (upper_tap)
    );

    // joined view: lower byte low, upper byte high
    assign wide_count = {upper_counter_q, lower_counter_q};
    assign wide_cmp   = {upper_compare_value_q, lower_compare_value_q};
    assign lower_match = (lower_counter_q == lower_compare_value_q);
    assign upper_match = (upper_counter_q == upper_compare_value_q);
    assign wide_match  = (wide_count == wide_cmp);

    // clock selection; external pin counts only for the lower counter
    assign lower_tick = lower_enable &&
        ((lower_clock_select == LSEL_EXT) ? ext_rise : lower_tap);
    assign lower_wrap = lower_tick && (wide_mode_select ? wide_match : lower_match);
    assign upper_tick = upper_enable &&
        ((upper_clock_select == USEL_CHAIN) ? lower_wrap : upper_tap);
    assign upper_wrap = !wide_mode_select && !pwm_enable_bit && upper_tick && upper_match;

    // capture events; the joined counter listens to the lower trigger
    assign lower_cap_evt = lower_capture_select && ltrg_rise;
    assign upper_cap_evt = !wide_mode_select && upper_capture_select && utrg_rise;

    // software writes; duty byte ignored while pwm is off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_compare_value_q <= CMP_RESET;
            upper_compare_value_q <= CMP_RESET;
            pwm_duty_byte_q       <= DUTY_RESET;
            pwm_high_q            <= HI_RESET;
            upper_output_enable_q <= 1'b0;
        end else begin
            if (lower_cmp_wr) begin
                lower_compare_value_q <= wr_data;
            end
            if (upper_cmp_wr) begin
                upper_compare_value_q <= wr_data;
            end
            if (pwm_duty_wr && pwm_enable_bit) begin
                pwm_duty_byte_q <= wr_data;
            end
            if (pwm_high_wr) begin
                pwm_high_q            <= wr_data[HI_W-1:0];
                upper_output_enable_q <= wr_data[BYTE_W-1];
            end
        end
    end

    // counting; capture clear outranks a tick in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_counter_q <= CNT_RESET;
            upper_counter_q <= CNT_RESET;
        end else if (wide_mode_select) begin
            if (lower_cap_evt) begin
                lower_counter_q <= CNT_RESET;
                upper_counter_q <= CNT_RESET;
            end else if (lower_wrap) begin
                lower_counter_q <= CNT_RESET;
                upper_counter_q <= CNT_RESET;
            end else if (lower_tick) begin
                {upper_counter_q, lower_counter_q} <= wide_count + WIDE_W'(1);
            end
        end else begin
            if (lower_cap_evt) begin
                lower_counter_q <= CNT_RESET;
            end else if (lower_wrap) begin
                lower_counter_q <= CNT_RESET;
            end else if (lower_tick) begin
                lower_counter_q <= lower_counter_q + BYTE_W'(1);
            end
            // the pwm engine owns its own period count
            if (upper_cap_evt || pwm_enable_bit) begin
                upper_counter_q <= CNT_RESET;
            end else if (upper_wrap) begin
                upper_counter_q <= CNT_RESET;
            end else if (upper_tick) begin
                upper_counter_q <= upper_counter_q + BYTE_W'(1);
            end
        end
    end

    // capture registers hold the count seen at the trigger edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_capture_value_q <= CAP_RESET;
            upper_capture_value_q <= CAP_RESET;
        end else begin
            if (lower_cap_evt) begin
                lower_capture_value_q <= lower_counter_q;
                if (wide_mode_select) begin
                    upper_capture_value_q <= upper_counter_q;
                end
            end
            if (upper_cap_evt) begin
                upper_capture_value_q <= upper_counter_q;
            end
        end
    end

    // match pulses; joined mode silences the upper one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_irq <= 1'b0;
            upper_irq <= 1'b0;
        end else begin
            lower_irq <= lower_wrap;
            upper_irq <= upper_wrap;
        end
    end

    // compare toggles give a 50:50 square wave
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_tog_q <= 1'b0;
            upper_tog_q <= 1'b0;
        end else begin
            if (lower_wrap) begin
                lower_tog_q <= !lower_tog_q;
            end
            if (wide_mode_select ? lower_wrap : upper_wrap) begin
                upper_tog_q <= !upper_tog_q;
            end
        end
    end

    dtc_pwm u_pwm (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (pwm_enable_bit),
        .advance  (upper_tick),
        .polarity (duty_level_select),
        .period   ({pwm_high_q[HI_PER_MSB:HI_PER_LSB], upper_compare_value_q}),
        .duty     ({pwm_high_q[HI_DUTY_MSB:HI_DUTY_LSB], pwm_duty_byte_q}),
        .level    (pwm_level)
    );

    // pins; the upper pin stays low until its enable is set
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_wave_pin <= 1'b0;
            upper_wave_pin <= 1'b0;
        end else begin
            lower_wave_pin <= lower_output_enable && lower_tog_q;
            upper_wave_pin <= upper_output_enable_q &&
                              (pwm_enable_bit ? pwm_level : upper_tog_q);
        end
    end

    // shared read port; capture mode opens the capture path
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_read_value   <= CNT_RESET;
            upper_read_value   <= CNT_RESET;
            pwm_duty_read      <= DUTY_RESET;
            ext_pin_input_mode <= 1'b0;
        end else begin
            lower_read_value   <= lower_capture_select ? lower_capture_value_q
                                                       : lower_counter_q;
            upper_read_value   <= (wide_mode_select ? lower_capture_select
                                                    : upper_capture_select)
                                  ? upper_capture_value_q : upper_counter_q;
            pwm_duty_read      <= pwm_duty_byte_q;
            ext_pin_input_mode <= (lower_clock_select == LSEL_EXT);
        end
    end

    sequence s_lower_cap;
        lower_cap_evt ##1 1'b1;
    endsequence

    a_capture_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        s_lower_cap |-> lower_counter_q == CNT_RESET)
        else $error("capture did not clear counter");

    a_capture_copy: assert property (@(posedge mclk) disable iff (!rst_n)
        lower_cap_evt |=> lower_capture_value_q == $past(lower_counter_q))
        else $error("capture value wrong");

    a_lower_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        (lower_tick && lower_match && !wide_mode_select && !lower_cap_evt)
        |=> lower_counter_q == CNT_RESET && lower_irq)
        else $error("lower counter did not wrap");

    a_lower_irq_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        lower_irq |-> $past(lower_tick) && $past(wide_mode_select ? wide_match : lower_match))
        else $error("lower interrupt without match");

    a_wide_no_upper: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(wide_mode_select) |-> !upper_irq)
        else $error("upper interrupt in joined mode");

    a_wide_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        (wide_mode_select && lower_tick && !lower_wrap && !lower_cap_evt
         && lower_counter_q == 8'hff) |=> upper_counter_q == $past(upper_counter_q) + 8'h01)
        else $error("joined carry lost");

    a_ext_input_dir: assert property (@(posedge mclk) disable iff (!rst_n)
        (lower_clock_select == LSEL_EXT) |=> ext_pin_input_mode)
        else $error("count pin not forced to input");

    a_upper_pin_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(upper_output_enable_q) |-> !upper_wave_pin)
        else $error("upper pin driven while disabled");

    a_capture_read: assert property (@(posedge mclk) disable iff (!rst_n)
        lower_capture_select |=> lower_read_value == $past(lower_capture_value_q))
        else $error("capture read path wrong");

endmodule : dtc_timer_top

/* File: test/dtc_pins_model.sv */
// pin-side partner: count pin and the two capture trigger pins
// assumes mclk is the block clock; pins change on its falling edge
`timescale 1ns/100ps
module dtc_pins_model (
    input  wire logic mclk,                  // system clock
    output logic      external_count_input,  // count pin
    output logic      lower_capture_trigger, // lower capture pin
    output logic      upper_capture_trigger  // upper capture pin
);
    // pins idle low between events
    initial begin
        external_count_input = 1'b0;
        lower_capture_trigger = 1'b0;
        upper_capture_trigger = 1'b0;
    end
    // wide pulses so the two-flop synchroniser never misses an edge
    task automatic pulse_ext(input int n);
        repeat (n) begin
            @(negedge mclk) external_count_input = 1'b1;
            repeat (4) @(negedge mclk);
            external_count_input = 1'b0;
            repeat (4) @(negedge mclk);
        end
    endtask : pulse_ext
    // one rising edge on the lower or the upper capture pin
    task automatic pulse_trig(input logic up);
        @(negedge mclk);
        if (up) upper_capture_trigger = 1'b1;
        else lower_capture_trigger = 1'b1;
        repeat (4) @(negedge mclk);
        {upper_capture_trigger, lower_capture_trigger} = 2'h0;
    endtask : pulse_trig
endmodule : dtc_pins_model

/* File: test/dtc_timer_top_tb.sv */
// self-checking bench for the paired timer/counter block
// assumes the pin partner model; inputs change on the falling edge
`timescale 1ns/100ps
module dtc_timer_top_tb import dtc_pkg::*; ;
    logic mclk, rst_n, lower_enable, lower_output_enable, lower_capture_select;
    logic upper_enable, duty_level_select, wide_mode_select, pwm_enable_bit;
    logic upper_capture_select, lower_cmp_wr, upper_cmp_wr, pwm_duty_wr, pwm_high_wr;
    logic [2:0] lower_clock_select;
    logic [1:0] upper_clock_select;
    logic [7:0] wr_data, lower_read_value, upper_read_value, pwm_duty_read;
    logic external_count_input, lower_capture_trigger, upper_capture_trigger;
    logic lower_irq, upper_irq, lower_wave_pin, upper_wave_pin, ext_pin_input_mode;
    int bad_count, n_tests, g, h, up_n, up_0;
    logic [8:0] pt[4] = '{9'h100, 9'h000, 9'h104, 9'h102}; // polarity, duty
    int pe[4] = '{0, 40, 40, 20};                          // high cycles of 40
    dtc_timer_top u_dut (.*);
    dtc_pins_model u_pins (.*);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // upper match pulses are counted; tests compare differences
    always @(posedge mclk) up_n <= up_n + int'(upper_irq === 1'b1);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // s: 0 lower compare, 1 upper compare/period, 2 duty, 3 high bits
    task automatic wr(input int s, input logic [7:0] d);
        @(negedge mclk);
        wr_data = d;
        {pwm_high_wr, pwm_duty_wr, upper_cmp_wr, lower_cmp_wr} = 4'h1 << s;
        @(negedge mclk);
        {pwm_high_wr, pwm_duty_wr, upper_cmp_wr, lower_cmp_wr} = 4'h0;
    endtask : wr
    // cycles between two lower match pulses, bounded
    task automatic gap(output int n);
        n = 1;
        for (int i = 0; i < 2000 && lower_irq !== 1'b1; i++) @(negedge mclk);
        @(negedge mclk);
        while (n < 2000 && lower_irq !== 1'b1) begin
            @(negedge mclk);
            n++;
        end
    endtask : gap
    task automatic hcount(output int k);
        k = 0;
        repeat (40) begin
            @(negedge mclk);
            k += int'(upper_wave_pin === 1'b1);
        end
    endtask : hcount
    task automatic rst(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
    endtask : rst
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // whole run is a few thousand cycles
    initial begin
        #(40 * 20000);
        bad_count++;
        report_and_stop;
    end
    initial begin
        {lower_enable, lower_capture_select, upper_enable} = 3'h0;
        {duty_level_select, wide_mode_select, pwm_enable_bit, upper_capture_select} = 4'h0;
        {lower_cmp_wr, upper_cmp_wr, pwm_duty_wr, pwm_high_wr} = 4'h0;
        lower_clock_select = LSEL_DIV2;
        upper_clock_select = USEL_DIV1;
        {wr_data, lower_output_enable, rst_n, bad_count, n_tests} = '0;
        rst(6);
        chk({upper_read_value, lower_read_value}, 16'h0000);
        $display("reset test done");
        wr(0, 8'h02);
        lower_enable = 1'b1;
        lower_output_enable = 1'b1;
        gap(g);
        chk(16'(g), 16'd6);
        h = int'(lower_wave_pin);
        repeat (6) @(negedge mclk);
        chk(16'(lower_wave_pin), 16'(h ^ 1));
        $display("timer test done");
        wr(0, 8'h01);
        wr(1, 8'h01);
        {upper_clock_select, wide_mode_select, upper_enable} = 4'hf;
        up_0 = up_n;
        gap(g);
        gap(g);
        chk(16'(g), 16'd516);
        chk(16'(up_n - up_0), 16'h0000);
        {upper_clock_select, wide_mode_select, upper_enable} = 4'h0;
        $display("wide test done");
        rst(2);
        lower_clock_select = LSEL_EXT;
        repeat (2) @(negedge mclk);
        chk(16'(ext_pin_input_mode), 16'h0001);
        u_pins.pulse_ext(5);
        repeat (6) @(negedge mclk);
        chk(16'(lower_read_value), 16'h0005);
        lower_capture_select = 1'b1;
        u_pins.pulse_trig(1'b0);
        u_pins.pulse_ext(3);
        repeat (6) @(negedge mclk);
        chk(16'(lower_read_value), 16'h0005);
        lower_capture_select = 1'b0;
        repeat (3) @(negedge mclk);
        chk(16'(lower_read_value), 16'h0003);
        $display("capture test done");
        wr(2, 8'h5a);
        repeat (2) @(negedge mclk);
        chk(16'(pwm_duty_read), 16'(DUTY_RESET));
        {pwm_enable_bit, upper_enable} = 2'h3;
        wr(1, 8'h04);
        wr(3, 8'h80);
        for (int i = 0; i < 4; i++) begin
            duty_level_select = pt[i][8];
            wr(2, pt[i][7:0]);
            repeat (10) @(negedge mclk);
            hcount(h);
            chk(16'(h), 16'(pe[i]));
        end
        wr(3, 8'h00);
        repeat (4) @(negedge mclk);
        chk(16'(upper_wave_pin), 16'h0000);
        chk(16'(pwm_duty_read), 16'h0002);
        $display("pwm test done");
        // compare output: compare 4 at /16 toggles the pin every 80 cycles
        {pwm_enable_bit, upper_clock_select} = 3'h2;
        wr(3, 8'h80);
        repeat (2) @(negedge mclk);
        h = int'(upper_wave_pin);
        up_0 = up_n;
        repeat (80) @(negedge mclk);
        chk(16'(upper_wave_pin), 16'(h ^ 1));
        chk(16'(up_n - up_0), 16'h0001);
        $display("compare test done");
        // upper capture: clear, count 7 ticks at /1, capture again
        {upper_enable, upper_clock_select, upper_capture_select} = 4'h1;
        wr(1, 8'hff);
        u_pins.pulse_trig(1'b1);
        upper_enable = 1'b1;
        repeat (7) @(negedge mclk);
        upper_enable = 1'b0;
        u_pins.pulse_trig(1'b1);
        repeat (2) @(negedge mclk);
        chk(16'(upper_read_value), 16'h0007);
        upper_capture_select = 1'b0;
        repeat (2) @(negedge mclk);
        chk(16'(upper_read_value), 16'h0000);
        $display("upper capture test done");
        report_and_stop;
    end
endmodule : dtc_timer_top_tb
